// >>> hdl/uswsw_pkg.sv
// uswsw_pkg: constants and carrier types for the usb pin single-wire switch
// assumes one 40 MHz system clock and synchronous pin samples
package uswsw_pkg;

  localparam int CNT_W = 20;
  localparam int PHASE_HI = 19;
  localparam int PHASE_LO = 18;
  localparam logic [1:0] PHASE_LOW_START = 2'h2;
  localparam logic [1:0] PHASE_DETECT = 2'h3;
  localparam logic [CNT_W-1:0] CNT_RESET = 20'h00000;
  localparam logic [CNT_W-1:0] CNT_ONE = 20'h00001;
  localparam int LINK_MAX_BPS = 2000000;
  localparam int CLK_HZ = 40000000;
  localparam int BIT_MIN_CYC = (CLK_HZ + LINK_MAX_BPS - 1) / LINK_MAX_BPS;

  typedef enum logic [1:0] {
    USWSW_IDLE = 2'b00,
    USWSW_HIGH = 2'b01,
    USWSW_LOW = 2'b11,
    USWSW_DONE = 2'b10
  } uswsw_state_e;

  typedef struct packed {
    logic dplus;
    logic dminus;
  } uswsw_pins_s;

  typedef struct packed {
    logic out;
    logic oe;
  } uswsw_drive_s;

endpackage

// >>> hdl/uswsw_cnt.sv
// uswsw_cnt: free counter for the switch-over sequence
// assumes the caller asserts clear for any malformed level
`timescale 1ns/1ps
`default_nettype none
module uswsw_cnt #(
  // one in silicon; a power of two shortens a long run
  parameter logic [uswsw_pkg::CNT_W-1:0] STEP = uswsw_pkg::CNT_ONE
) (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_clear,
  input wire logic i_run,
  output logic [uswsw_pkg::CNT_W-1:0] o_cnt
);
  logic [uswsw_pkg::CNT_W-1:0] next_cnt;

  always_comb begin
    next_cnt = o_cnt;
    if (i_clear) begin
      next_cnt = uswsw_pkg::CNT_RESET;
    end else if (i_run) begin
      // saturate so phase 11 never wraps back to 00
      if (o_cnt[uswsw_pkg::PHASE_HI:uswsw_pkg::PHASE_LO] !=
          uswsw_pkg::PHASE_DETECT) begin
        next_cnt = o_cnt + STEP;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_cnt <= uswsw_pkg::CNT_RESET;
    end else begin
      o_cnt <= next_cnt;
    end
  end
endmodule
`default_nettype wire

// >>> hdl/uswsw_top.sv
// uswsw_top: detects the d+/d- switch-over sequence and hands the d+ pad
// to the single_wire_slave; assumes pins already synchronous to i_mclk
//
// Overview of operation
// [R01] after reset the shared d+ pad carries usb d+, slave only after detect
// [R02] sequence is watched only while the detection enable input is 1
// [R03] master holds d- high during the whole sequence
// [R04] d+ high until counter bits 19:18 reach 10, then low until 11
// [R05] detection flag sets when bits 19:18 reach 11 with d+ held low
// [R06] on detect, select flag sets and slave data drives the d+ pad
// [R07] at 24 MHz the master holds about 22 ms high, 11 ms low
// [R08] single-wire link traffic stays at or below 2 Mbps
// [R09] slave path is not served in deep sleep or suspend; code only gates the slave oe with i_low_power, o_slave_in still follows d+
// [R10] counter restarts on d- low or out-of-order d+ level
`timescale 1ns/1ps
`default_nettype none
module uswsw_top #(
  // counter increment; one in silicon, a power of two shortens a run
  parameter logic [uswsw_pkg::CNT_W-1:0] CNT_STEP = uswsw_pkg::CNT_ONE
) (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_detect_en,
  input wire logic i_low_power,
  input wire uswsw_pkg::uswsw_pins_s i_pins,
  input wire logic i_slave_out,
  input wire logic i_slave_oe,
  input wire uswsw_pkg::uswsw_drive_s i_usb_dplus,
  output var uswsw_pkg::uswsw_drive_s o_dplus_pad,
  output logic o_usb_dplus_in,
  output logic o_slave_in,
  output logic o_detect,
  output logic o_select
);
  uswsw_pkg::uswsw_state_e state;
  uswsw_pkg::uswsw_state_e next_state;
  logic next_detect;
  logic next_select;
  logic cnt_clear;
  logic cnt_run;
  logic [1:0] phase;
  logic [uswsw_pkg::CNT_W-1:0] cnt;
  uswsw_pkg::uswsw_drive_s next_pad;
  logic next_usb_in;
  logic next_slave_in;
  logic armed;
  logic dplus_high;
  logic drop_ok;
  logic at_detect;
  logic in_low;
  logic hit;

  assign phase = cnt[uswsw_pkg::PHASE_HI:uswsw_pkg::PHASE_LO];

  // decodes shared by the state and flag groups
  assign armed = i_detect_en && i_pins.dminus; // [R02] [R03]
  assign dplus_high = i_pins.dplus;
  assign drop_ok = (phase == uswsw_pkg::PHASE_LOW_START); // [R04]
  assign at_detect = (phase == uswsw_pkg::PHASE_DETECT); // [R05]
  assign in_low = (state == uswsw_pkg::USWSW_LOW);
  assign hit = in_low && armed && !dplus_high && at_detect; // [R05]

  uswsw_cnt #(
    .STEP(CNT_STEP)
  ) u_cnt (
    .i_mclk(i_mclk),
    .i_srst(i_srst),
    .i_clear(cnt_clear),
    .i_run(cnt_run),
    .o_cnt(cnt)
  );

  // sequence state
  always_comb begin
    next_state = state;
    case (state)
      uswsw_pkg::USWSW_IDLE: begin
        // watch only while armed and d- high [R02] [R03]
        if (armed && dplus_high) begin
          next_state = uswsw_pkg::USWSW_HIGH;
        end
      end
      uswsw_pkg::USWSW_HIGH: begin
        if (!armed) begin
          next_state = uswsw_pkg::USWSW_IDLE; // [R10]
        end else if (!dplus_high) begin
          // d+ may drop only while the phase is 10; a drop in phase 11 restarts [R04]
          if (drop_ok) begin
            next_state = uswsw_pkg::USWSW_LOW;
          end else begin
            next_state = uswsw_pkg::USWSW_IDLE; // [R10]
          end
        end
      end
      uswsw_pkg::USWSW_LOW: begin
        if (!armed || dplus_high) begin
          next_state = uswsw_pkg::USWSW_IDLE; // [R10] [R04]
        end else if (at_detect) begin
          next_state = uswsw_pkg::USWSW_DONE;
        end
      end
      uswsw_pkg::USWSW_DONE: begin
        // stays switched until reset; nothing hands the pad back
        next_state = uswsw_pkg::USWSW_DONE;
      end
      default: begin
        next_state = uswsw_pkg::USWSW_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      state <= uswsw_pkg::USWSW_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // counter control; idle holds it at zero so every try starts clean
  always_comb begin
    cnt_clear = 1'b0;
    cnt_run = 1'b0;
    case (state)
      uswsw_pkg::USWSW_IDLE: begin
        cnt_clear = 1'b1; // [R10]
      end
      uswsw_pkg::USWSW_HIGH: begin
        cnt_run = 1'b1; // [R04]
      end
      uswsw_pkg::USWSW_LOW: begin
        cnt_run = 1'b1; // [R04]
      end
      uswsw_pkg::USWSW_DONE: begin
        // frozen once switched, saves toggling a 20-bit adder
        cnt_run = 1'b0;
      end
      default: begin
        cnt_clear = 1'b1;
      end
    endcase
  end

  // sticky flags
  always_comb begin
    next_detect = o_detect;
    next_select = o_select;
    if (hit) begin
      next_detect = 1'b1; // [R05]
      next_select = 1'b1; // [R06]
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_detect <= 1'b0;
      o_select <= 1'b0; // [R01]
    end else begin
      o_detect <= next_detect;
      o_select <= next_select;
    end
  end

  // pad drive, registered so every output leaves a flip-flop
  // one flop of lag is far below a 2 Mbps bit, so no rate logic [R08]
  always_comb begin
    if (o_select) begin
      // slave released in low power so the pad floats quietly [R09] [R06]
      next_pad.out = i_slave_out;
      next_pad.oe = i_slave_oe && !i_low_power;
    end else begin
      next_pad = i_usb_dplus; // [R01]
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_dplus_pad <= '0;
    end else begin
      o_dplus_pad <= next_pad;
    end
  end

  // d+ return path; the unused side idles high like a released line
  always_comb begin
    if (o_select) begin
      next_usb_in = 1'b1;
      next_slave_in = i_pins.dplus; // [R06]
    end else begin
      next_usb_in = i_pins.dplus; // [R01]
      next_slave_in = 1'b1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_usb_dplus_in <= 1'b1;
      o_slave_in <= 1'b1;
    end else begin
      o_usb_dplus_in <= next_usb_in;
      o_slave_in <= next_slave_in;
    end
  end
endmodule
`default_nettype wire

// >>> verification/uswsw_master.sv
// uswsw_master: single_wire_master model driving usb d+ and d-
// assumes a free-running i_mclk; idle shows a usb j state
`timescale 1ns/1ps
`default_nettype none
module uswsw_master (
  input wire logic i_mclk,
  output var uswsw_pkg::uswsw_pins_s o_pins
);
  // d- low when idle so an enabled device never starts counting by itself
  initial o_pins = 2'h2;
  task automatic run(input int hi, input int lo);
    @(posedge i_mclk) o_pins <= 2'h3;
    repeat (hi) @(posedge i_mclk);
    o_pins <= 2'h1;
    repeat (lo) @(posedge i_mclk);
    o_pins <= 2'h2;
  endtask
endmodule
`default_nettype wire

// >>> verification/uswsw_top_sva.sv
// uswsw_top_sva: port checker bound into uswsw_top
// assumes one clock i_mclk and sync reset i_srst
`timescale 1ns/1ps
`default_nettype none
module uswsw_top_sva (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_detect_en,
  input wire logic i_low_power,
  input wire uswsw_pkg::uswsw_pins_s i_pins,
  input wire logic i_slave_out,
  input wire logic i_slave_oe,
  input wire uswsw_pkg::uswsw_drive_s i_usb_dplus,
  input wire uswsw_pkg::uswsw_drive_s o_dplus_pad,
  input wire logic o_usb_dplus_in,
  input wire logic o_slave_in,
  input wire logic o_detect,
  input wire logic o_select
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  a_reset_clear: assert property (disable iff (1'b0)
    i_srst |=> !o_detect && !o_select && o_slave_in) else $error("reset");
  a_usb_path: assert property (!o_select |=>
    o_dplus_pad == $past(i_usb_dplus) && o_slave_in &&
    o_usb_dplus_in == $past(i_pins.dplus)) else $error("usb path");
  a_slave_path: assert property (o_select |=>
    o_dplus_pad.out == $past(i_slave_out) && o_usb_dplus_in &&
    o_dplus_pad.oe == ($past(i_slave_oe) && !$past(i_low_power)) &&
    o_slave_in == $past(i_pins.dplus)) else $error("slave path");
  a_flags_sticky: assert property (o_detect |=>
    o_detect && o_select) else $error("flag dropped");
  a_detect_cause: assert property ($rose(o_detect) |->
    $rose(o_select) && $past(i_pins) == 2'h1 && $past(i_detect_en))
    else $error("detect cause");
  a_enable_gate: assert property (!i_detect_en && !o_detect |=>
    !o_detect) else $error("detect while disabled");
  a_dminus_abort: assert property (!i_pins.dminus && !o_detect |=>
    !o_detect) else $error("detect with d- low");
  a_dplus_high: assert property (i_pins.dplus && !o_detect |=>
    !o_detect) else $error("detect with d+ high");
  cover property ($rose(o_detect));
  cover property (o_select && i_slave_oe && i_low_power);
  cover property (i_pins == 2'h1 && !o_detect);
endmodule
bind uswsw_top uswsw_top_sva u_uswsw_top_sva (.*);
`default_nettype wire

// >>> verification/uswsw_top_tb.sv
// uswsw_top_tb: self-checking bench for uswsw_top
// assumes a counter step of 16, so one good sequence runs about 50k cycles
`timescale 1ns/1ps
`default_nettype none
module uswsw_top_tb;
  logic i_mclk = 0, i_srst = 1, i_detect_en = 0, i_low_power = 0;
  logic i_slave_out = 0, i_slave_oe = 0;
  uswsw_pkg::uswsw_drive_s i_usb_dplus = '0, o_dplus_pad;
  uswsw_pkg::uswsw_pins_s i_pins;
  logic o_usb_dplus_in, o_slave_in, o_detect, o_select;
  logic [31:0] rng = 32'hED54;
  int num_errors = 0, n_compared = 0;
  uswsw_top #(.CNT_STEP(20'h00010)) u_uswsw_top (.*);
  uswsw_master u_uswsw_master (.i_mclk(i_mclk), .o_pins(i_pins));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  initial forever #12.5 i_mclk = ~i_mclk;
  always @(posedge i_mclk) begin
    rng <= xs(rng);
    {i_slave_out, i_slave_oe, i_usb_dplus, i_low_power} <= rng[4:0];
  end
  task automatic chk(input logic ok, input string m);
    n_compared++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  function automatic uswsw_pkg::uswsw_drive_s exp_pad(input logic sel);
    uswsw_pkg::uswsw_drive_s d;
    d.out = i_slave_out;
    d.oe = i_slave_oe && !i_low_power;
    return sel ? d : i_usb_dplus;
  endfunction
  // call just after an edge; checks 8 cycles of the registered pad path
  task automatic pad_check(input logic sel);
    uswsw_pkg::uswsw_drive_s ep;
    logic ed;
    for (int k = 0; k < 8; k++) begin
      ep = exp_pad(sel);
      ed = i_pins.dplus;
      @(posedge i_mclk) #1;
      chk(o_dplus_pad === ep, "pad drive");
      chk((sel ? o_slave_in : o_usb_dplus_in) === ed, "d+ path");
    end
  endtask
  task automatic close_out;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge i_mclk);
    i_srst <= 1'b0;
    @(posedge i_mclk) i_detect_en <= 1'b1;
    #1 chk(o_detect === 1'b0 && o_slave_in === 1'b1, "reset state");
    pad_check(1'b0);
    // early d+ drop must restart, not detect
    u_uswsw_master.run(1000, 1000);
    #1 chk(o_detect === 1'b0, "early drop detected");
    u_uswsw_master.run(40000, 10000);
    #1 chk(o_detect === 1'b1 && o_select === 1'b1, "no detect");
    repeat (200) @(posedge i_mclk);
    #1 chk(o_usb_dplus_in === 1'b1, "usb not isolated");
    pad_check(1'b1);
    close_out();
  end
endmodule
`default_nettype wire
